// file: rtl/ivec_pkg.sv
// ==========================================================
// Register map, field layout and carriers for the vector registers
package ivec_pkg;

  // ========================================================
  // Register offsets within the node space
  localparam logic [7:0] DEST_MASK_ADDR  = 8'h48;
  localparam logic [7:0] VEC_OFFSET_ADDR = 8'h50;
  localparam logic [7:0] OWN_VEC_ADDR    = 8'h54;

  // ========================================================
  // Field positions and widths
  localparam int OFFSET_LSB    = 9;
  localparam int OFFSET_MSB    = 15;
  localparam int OFFSET_WIDTH  = 7;
  localparam int CHECK_LSB     = 9;
  localparam int CHECK_MSB     = 13;
  localparam int OWN_VEC_LSB   = 2;
  localparam int OWN_VEC_MSB   = 15;
  localparam int OWN_VEC_WIDTH = 14;
  localparam int MASK_WIDTH    = 16;
  localparam int VEC_WIDTH     = 16;
  localparam int NODE_WIDTH    = 4;
  localparam int IPL_WIDTH     = 2;

  // ========================================================
  // Reset values
  localparam logic [OFFSET_WIDTH-1:0]  OFFSET_RESET  = 7'h00;
  localparam logic [OWN_VEC_WIDTH-1:0] OWN_VEC_RESET = 14'h0000;
  localparam logic [MASK_WIDTH-1:0]    MASK_RESET    = 16'h0000;
  localparam logic [31:0]              RDATA_RESET   = 32'h00000000;

  // ========================================================
  // Carriers
  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic                  valid;
    logic [NODE_WIDTH-1:0] node;
    logic [IPL_WIDTH-1:0]  ipl;
  } ident_req_t;

  typedef struct packed {
    logic                 valid;
    logic [VEC_WIDTH-1:0] vector;
  } vec_t;

endpackage : ivec_pkg

// file: rtl/ivec_regs.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Join offset to I/O-side vector only when its bits 13:9 are zero.
// - Offset is a 7-bit read/write field at bits 15:9, reset zero.
// - Own vector sits at bits 15:2, reset zero; bits 1:0 read zero.
// - Return own vector to an identify matching the pending own request.
// - Own vector answers only own interrupts, never I/O-side ones.
// - Reserved bits read zero; software writes them as zero.
// - Own interrupt goes to every node set in the 16-bit mask.
module ivec_regs #(
  parameter logic [3:0] NODE_ID = 4'h0  // Own node number, arbitrary default
) (
  // Clock and reset
  input  wire logic                CLK_SYS_IN,
  input  wire logic                RST_N_IN,
  // Register access
  input  wire ivec_pkg::reg_req_t  REG_REQ_IN,
  output logic [31:0]              REG_RDATA_OUT,
  output logic                     REG_RVALID_OUT,
  // I/O-side vector path
  input  wire ivec_pkg::vec_t      IO_VEC_IN,
  output var ivec_pkg::vec_t       FWD_VEC_OUT,
  // Own interrupt request
  input  wire logic                OWN_IRQ_IN,
  input  wire logic [1:0]          OWN_IPL_IN,
  output logic                     INTR_REQ_OUT,
  output logic [15:0]              INTR_DEST_OUT,
  output logic [1:0]               INTR_IPL_OUT,
  // Identify handshake
  input  wire ivec_pkg::ident_req_t IDENT_REQ_IN,
  output var ivec_pkg::vec_t       IDENT_RESP_OUT
);
  import ivec_pkg::*;

  // ========================================================
  // Storage
  logic [OFFSET_WIDTH-1:0]  offset_field;
  logic [OWN_VEC_WIDTH-1:0] own_vec;
  logic [MASK_WIDTH-1:0]    dest_mask;
  logic                     irq_prev;
  logic [VEC_WIDTH-1:0]     merged_vec;
  logic                     merge_applied;
  logic                     ident_match;
  logic [31:0]              next_rdata;

  // Offset register write, upper and lower bits discarded
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      offset_field <= OFFSET_RESET;
    end else if (REG_REQ_IN.write && REG_REQ_IN.addr == VEC_OFFSET_ADDR) begin
      offset_field <= REG_REQ_IN.wdata[OFFSET_MSB:OFFSET_LSB];
    end
  end

  // Own vector register write
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      own_vec <= OWN_VEC_RESET;
    end else if (REG_REQ_IN.write && REG_REQ_IN.addr == OWN_VEC_ADDR) begin
      own_vec <= REG_REQ_IN.wdata[OWN_VEC_MSB:OWN_VEC_LSB];
    end
  end

  // Destination mask write
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dest_mask <= MASK_RESET;
    end else if (REG_REQ_IN.write && REG_REQ_IN.addr == DEST_MASK_ADDR) begin
      dest_mask <= REG_REQ_IN.wdata[MASK_WIDTH-1:0];
    end
  end

  // ========================================================
  // Read path, reserved and unmapped bits read zero
  always_comb begin
    next_rdata = RDATA_RESET;
    unique case (REG_REQ_IN.addr)
      DEST_MASK_ADDR: begin
        next_rdata[MASK_WIDTH-1:0] = dest_mask;
      end
      VEC_OFFSET_ADDR: begin
        next_rdata[OFFSET_MSB:OFFSET_LSB] = offset_field;
      end
      OWN_VEC_ADDR: begin
        next_rdata[OWN_VEC_MSB:OWN_VEC_LSB] = own_vec;
      end
      default: begin
        next_rdata = RDATA_RESET;
      end
    endcase
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT  <= RDATA_RESET;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= REG_REQ_IN.read;
      if (REG_REQ_IN.read) begin
        REG_RDATA_OUT <= next_rdata;
      end
    end
  end

  // ========================================================
  // I/O-side vector forwarding
  vec_merge #(
    .VW (VEC_WIDTH),
    .OW (OFFSET_WIDTH),
    .CL (CHECK_LSB),
    .CH (CHECK_MSB)
  ) u_merge (
    .vec_in      (IO_VEC_IN.vector),
    .offset_in   (offset_field),
    .vec_out     (merged_vec),
    .applied_out (merge_applied)
  );

  // Forwarded vector never carries the own vector
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FWD_VEC_OUT <= '0;
    end else begin
      FWD_VEC_OUT.valid  <= IO_VEC_IN.valid;
      FWD_VEC_OUT.vector <= merged_vec;
    end
  end

  // ========================================================
  // Own interrupt transaction on the rising request
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_prev      <= 1'b0;
      INTR_REQ_OUT  <= 1'b0;
      INTR_DEST_OUT <= MASK_RESET;
      INTR_IPL_OUT  <= 2'h0;
    end else begin
      irq_prev     <= OWN_IRQ_IN;
      INTR_REQ_OUT <= OWN_IRQ_IN && !irq_prev;
      if (OWN_IRQ_IN && !irq_prev) begin
        INTR_DEST_OUT <= dest_mask;
        INTR_IPL_OUT  <= OWN_IPL_IN;
      end
    end
  end

  // Identify answered only for a matching pending own request
  assign ident_match = IDENT_REQ_IN.valid && OWN_IRQ_IN &&
                       IDENT_REQ_IN.node == NODE_ID &&
                       IDENT_REQ_IN.ipl == OWN_IPL_IN;

  // Answer registered one cycle after the identify, vector holds after
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IDENT_RESP_OUT <= '0;
    end else begin
      IDENT_RESP_OUT.valid <= ident_match;
      if (ident_match) begin
        IDENT_RESP_OUT.vector <= {own_vec, 2'b00};
      end
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  a_merge_applied: assert property (
    IO_VEC_IN.valid && IO_VEC_IN.vector[13:9] == 5'h00 |=>
      FWD_VEC_OUT.vector[15:9] == $past(offset_field))
    else $error("offset not applied");

  a_merge_bypass: assert property (
    IO_VEC_IN.valid && IO_VEC_IN.vector[13:9] != 5'h00 |=>
      FWD_VEC_OUT.vector == $past(IO_VEC_IN.vector))
    else $error("vector altered");

  a_merge_flag: assert property (
    merge_applied == (IO_VEC_IN.vector[13:9] == 5'h00))
    else $error("offset check flag wrong");

  a_offset_write: assert property (
    REG_REQ_IN.write && REG_REQ_IN.addr == 8'h50 ##1
      REG_REQ_IN.read && REG_REQ_IN.addr == 8'h50 && !REG_REQ_IN.write |=>
      REG_RDATA_OUT[15:9] == $past(REG_REQ_IN.wdata[15:9], 2))
    else $error("offset readback wrong");

  a_own_vec_read: assert property (
    REG_REQ_IN.read && REG_REQ_IN.addr == 8'h54 |=>
      REG_RDATA_OUT[1:0] == 2'b00 && REG_RDATA_OUT[15:2] == $past(own_vec) &&
      REG_RDATA_OUT[31:16] == 16'h0000)
    else $error("own vector readback wrong");

  a_reserved_zero: assert property (
    REG_REQ_IN.read && REG_REQ_IN.addr == 8'h50 |=>
      REG_RDATA_OUT[31:16] == 16'h0000 && REG_RDATA_OUT[8:0] == 9'h000)
    else $error("reserved bits not zero");

  a_ident_answer: assert property (
    IDENT_REQ_IN.valid && OWN_IRQ_IN && IDENT_REQ_IN.node == NODE_ID &&
      IDENT_REQ_IN.ipl == OWN_IPL_IN |=> IDENT_RESP_OUT.valid &&
      IDENT_RESP_OUT.vector == {$past(own_vec), 2'b00})
    else $error("identify not answered");

  a_ident_silent: assert property (
    IDENT_REQ_IN.valid && (IDENT_REQ_IN.node != NODE_ID ||
      IDENT_REQ_IN.ipl != OWN_IPL_IN) |=> !IDENT_RESP_OUT.valid)
    else $error("identify answered without a match");

  a_ident_only_own: assert property (
    IDENT_RESP_OUT.valid |-> $past(OWN_IRQ_IN) && $past(IDENT_REQ_IN.valid))
    else $error("own vector sent without own request");

  a_dest_mask: assert property (
    $rose(OWN_IRQ_IN) |=> INTR_REQ_OUT && INTR_DEST_OUT == $past(dest_mask)
      ##1 !INTR_REQ_OUT)
    else $error("interrupt destination wrong");

endmodule : ivec_regs
`default_nettype wire

// file: rtl/vec_merge.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Joins the stored offset onto an I/O-side vector when its check
// field is clear; otherwise the vector passes unchanged
module vec_merge #(
  parameter int VW = 16,
  parameter int OW = 7,
  parameter int CL = 9,
  parameter int CH = 13
) (
  // Inputs
  input  wire logic [VW-1:0] vec_in,
  input  wire logic [OW-1:0] offset_in,
  // Outputs
  output logic      [VW-1:0] vec_out,
  output logic               applied_out
);

  // Offset applies only when the check field is all zero
  always_comb begin
    applied_out = (vec_in[CH:CL] == '0);
    if (applied_out) begin
      vec_out = {offset_in, vec_in[VW-OW-1:0]};
    end else begin
      vec_out = vec_in;
    end
  end

endmodule : vec_merge
`default_nettype wire

// file: testbench/node_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// System-bus node issuing identify cycles
module node_model
  import ivec_pkg::*;
(
  // Clock
  input  wire logic                 clk_in,
  // Answer from the adapter
  input  wire ivec_pkg::vec_t       resp_in,
  // Identify request
  output var ivec_pkg::ident_req_t  req_out
);
  logic        got;
  logic [15:0] vec;

  // Idle until a cycle is issued
  initial req_out = '0;

  // One-cycle identify, answer captured one cycle later
  task automatic identify(input logic [3:0] node, input logic [1:0] ipl);
    @(posedge clk_in);
    req_out <= ident_req_t'{1'b1, node, ipl};
    @(posedge clk_in);
    req_out <= '0;
    #1;
    got = resp_in.valid;
    vec = resp_in.vector;
  endtask : identify
endmodule : node_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the vector registers
module testbench;
  import ivec_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  reg_req_t    req = '0;
  vec_t        io_vec = '0;
  logic        own_irq = 1'b0;
  logic [1:0]  own_ipl = 2'h0;
  ident_req_t  ident;
  logic [31:0] rdata;
  logic        rvalid;
  vec_t        fwd;
  logic        intr_req;
  logic [15:0] intr_dest;
  logic [1:0]  intr_ipl;
  vec_t        resp;
  int          fail_count = 0;
  int          n_compared = 0;
  // I/O-side vectors and their forwarded forms with offset 7'h52
  logic [15:0] vin [4] = '{16'h0012, 16'h0200, 16'hC1FF, 16'h3E00};
  logic [15:0] vexp [4] = '{16'hA412, 16'h0200, 16'hA5FF, 16'h3E00};

  // Clock at 25 MHz
  always #20 clk = ~clk;

  ivec_regs #(.NODE_ID(4'h5)) dut (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .REG_REQ_IN(req),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .IO_VEC_IN(io_vec),
    .FWD_VEC_OUT(fwd), .OWN_IRQ_IN(own_irq), .OWN_IPL_IN(own_ipl),
    .INTR_REQ_OUT(intr_req), .INTR_DEST_OUT(intr_dest),
    .INTR_IPL_OUT(intr_ipl), .IDENT_REQ_IN(ident), .IDENT_RESP_OUT(resp)
  );

  node_model node (.clk_in(clk), .resp_in(resp), .req_out(ident));

  // ========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= reg_req_t'{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req <= reg_req_t'{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, exp);
  endtask : reg_read

  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(VEC_OFFSET_ADDR, 32'h0);
    reg_read(OWN_VEC_ADDR, 32'h0);
    reg_read(DEST_MASK_ADDR, 32'h0);
    reg_write(VEC_OFFSET_ADDR, 32'hFFFFFFFF);
    reg_write(OWN_VEC_ADDR, 32'hFFFFFFFF);
    reg_read(VEC_OFFSET_ADDR, 32'h0000FE00);
    reg_read(OWN_VEC_ADDR, 32'h0000FFFC);
    // Offset written and read back in consecutive cycles
    @(posedge clk);
    req <= reg_req_t'{1'b1, 1'b0, VEC_OFFSET_ADDR, 32'h0000A400};
    @(posedge clk);
    req <= reg_req_t'{1'b0, 1'b1, VEC_OFFSET_ADDR, 32'h00000000};
    @(posedge clk);
    req <= '0;
    #1;
    check({31'h0, rvalid}, 32'h1);
    check(rdata, 32'h0000A400);
    reg_write(OWN_VEC_ADDR, 32'h0000BEEC);
    reg_write(DEST_MASK_ADDR, 32'h00008001);
    reg_read(OWN_VEC_ADDR, 32'h0000BEEC);
    reg_read(DEST_MASK_ADDR, 32'h00008001);
    reg_read(8'h60, 32'h0);
    // Own request goes to the mask, only once per rise
    @(posedge clk);
    own_ipl <= 2'h2;
    own_irq <= 1'b1;
    @(posedge clk);
    #1;
    check({13'h0, intr_req, intr_ipl, intr_dest}, 32'h00068001);
    @(posedge clk);
    #1;
    check({31'h0, intr_req}, 32'h0);
    // Back-to-back I/O vectors while the own request is pending
    for (int i = 0; i <= 4; i++) begin
      @(posedge clk);
      io_vec <= (i < 4) ? vec_t'{1'b1, vin[i]} : vec_t'('0);
      #1;
      if (i > 0) begin
        check({15'h0, fwd}, {16'h0001, vexp[i-1]});
      end
    end
    // Identify: wrong node, wrong level, match, then no longer pending
    node.identify(4'h1, 2'h2);
    check({31'h0, node.got}, 32'h0);
    node.identify(4'h5, 2'h1);
    check({31'h0, node.got}, 32'h0);
    node.identify(4'h5, 2'h2);
    check({15'h0, node.got, node.vec}, 32'h0001BEEC);
    @(posedge clk);
    own_irq <= 1'b0;
    node.identify(4'h5, 2'h2);
    check({31'h0, node.got}, 32'h0);
    end_of_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (400) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
